/* verilog/rmwd_decoder.sv */
/*
 * Instruction decoder and read-modify-write sequencer of a small
 * accumulator core, with its working register and status bits.
 * Assumes program memory on clk_in presenting a word on instr_in combinationally
 * in the cycle after fetch_out is high, a file array that returns read data combinationally in the
 * same cycle as a read request, a PC unit obeying pc_req_out, and an APB master on clk_in.
 */
// How it works
// RQ1 - Every file instruction reads its register, modifies, then writes back; the bit-test skip forms read but write nothing back.
// RQ2 - Destination bit 0 sends result to W, 1 to the file register.
// RQ3 - File address field is seven bits, 0x00 to 0x7F.
// RQ4 - Bit field picks one of eight bit positions.
// RQ5 - Don't-care opcode bits decode the same either way.
// RQ6 - Prefix 00: 0110 xor, 0100 or, 0101 and with W; zero flag only.
// RQ7 - Prefix 00: 1101 rotates left, 1100 right, through carry; carry only.
// RQ8 - 1011 decrements, 1111 increments, skip next if zero; no flags.
// RQ9 - Prefix 01: clear, set, skip-if-clear, skip-if-set; bit index, address.
// RQ10 - One cycle, two when PC changes or skip taken; second is a no-op.
// RQ11 - Reading the I/O port uses the pin levels, not the latch.
// RQ12 - Writing the timer register clears the prescaler when assigned to it.
// RQ13 - Reading the port counts as a port read, clearing the mismatch.
// RQ14 - Standby and watchdog-clear opcodes set timeout and powerdown status.
// RQ15 - Return-literal, return and return-from-interrupt take two cycles.
// RQ16 - Prefix 11: 1010 xor, 1000 or, 1001 and literal into W; zero flag.
// RQ17 - 111x adds literal with C, DC, Z; 00xx loads literal, no flags.
// RQ18 - One instruction cycle spans four oscillator periods.
// RQ19 - Literals are eight bits, call and jump targets eleven.
// RQ20 - Prefix 10: bit 11 low calls and pushes, high jumps; two cycles.
// RQ21 - Prefix 00: 0111 adds, 0010 subtracts W from file; C, DC, Z.
`include "rmwd_regs.svh"
`default_nettype none

module rmwd_decoder #(
    parameter logic [6:0] PORT_ADDR = 7'h05,
    parameter logic [6:0] TIMER_ADDR = 7'h01
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Program memory.
    input wire logic [13:0] instr_in,
    output logic fetch_out,
    // File registers and port pins.
    input wire logic [7:0] file_rdata_in,
    input wire logic [7:0] port_pins_in,
    output rmwd_pkg::rmwd_file_req_t file_req_out,
    output logic port_read_out,
    output logic presc_clr_out,
    // Program counter and power control.
    output rmwd_pkg::rmwd_pc_req_t pc_req_out,
    output logic wdt_clr_out,
    output logic sleep_out,
    // Datapath state.
    output logic [7:0] w_out,
    output logic [4:0] status_out,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out
);

    rmwd_pkg::rmwd_state_t s_q;
    rmwd_pkg::rmwd_state_t s_d;

    logic [1:0] pfx;
    logic [3:0] nib;
    logic dbit;
    logic [2:0] bsel;
    logic [7:0] lit;
    logic [7:0] fop;
    logic [8:0] sum;
    logic take_skip;
    logic [7:0] bmask;
    logic setup;

    // Operand fields of the held instruction word.
    assign pfx = s_q.instr[13:12];
    assign nib = s_q.instr[11:8];
    assign dbit = s_q.instr[7];
    assign bsel = s_q.instr[9:7]; // [RQ4]
    assign lit = s_q.instr[7:0]; // [RQ19]
    assign fop = s_q.fval;
    assign bmask = 8'h01 << bsel; // [RQ4]
    assign setup = psel_in && !penable_in && !s_q.pready;

    always_comb
    begin
        s_d = s_q;
        sum = 9'h000;
        take_skip = 1'b0;
        // Pins pass two flops before anything reads them.
        s_d.pin_s1 = port_pins_in;
        s_d.pin_s2 = s_q.pin_s1;
        s_d.fetch = 1'b0;
        s_d.port_read = 1'b0;
        s_d.presc_clr = 1'b0;
        s_d.wdt_clr = 1'b0;
        s_d.file.rd = 1'b0;
        s_d.file.wr = 1'b0;
        s_d.pc.load = 1'b0;
        s_d.pc.push = 1'b0;
        s_d.pc.pop = 1'b0;
        s_d.pc.irq_return = 1'b0;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;

        case (s_q.phase)
            // Each quarter is one clock, four per instruction cycle. [RQ18]
            rmwd_pkg::PH_DECODE:
            begin
                if (s_q.run && !s_q.sleeping)
                begin
                    s_d.phase = rmwd_pkg::PH_READ;
                    s_d.file.addr = s_q.instr[6:0]; // [RQ3]
                    s_d.wr_file = 1'b0;
                    s_d.wr_w = 1'b0;
                    // Any file form reads first, even a pure write. [RQ1]
                    s_d.file.rd = !s_q.flush && (pfx == 2'b00 || pfx == 2'b01);
                end
            end
            rmwd_pkg::PH_READ:
            begin
                s_d.phase = rmwd_pkg::PH_MODIFY;
                if (s_q.file.addr == PORT_ADDR)
                begin
                    s_d.fval = s_q.pin_s2; // [RQ11]
                    s_d.port_read = s_q.file.rd; // [RQ13]
                end
                else
                begin
                    s_d.fval = file_rdata_in;
                end
                s_d.fetch = 1'b1;
            end
            rmwd_pkg::PH_MODIFY:
            begin
                s_d.phase = rmwd_pkg::PH_WRITE;
                s_d.res = fop;
                if (!s_q.flush)
                begin
                    case (pfx)
                        2'b00:
                        begin
                            s_d.wr_file = dbit; // [RQ2]
                            s_d.wr_w = !dbit; // [RQ2]
                            case (nib)
                                4'h0:
                                begin
                                    s_d.wr_w = 1'b0;
                                    s_d.res = s_q.w;
                                    if (s_q.instr[7:0] == 8'h63)
                                    begin
                                        s_d.sleeping = 1'b1;
                                        s_d.to_n = 1'b1; // [RQ14]
                                        s_d.pd_n = 1'b0; // [RQ14]
                                    end
                                    else if (s_q.instr[7:0] == 8'h64)
                                    begin
                                        s_d.wdt_clr = 1'b1;
                                        s_d.to_n = 1'b1; // [RQ14]
                                        s_d.pd_n = 1'b1; // [RQ14]
                                    end
                                    else if (s_q.instr[7:0] == 8'h08 || s_q.instr[7:0] == 8'h09)
                                    begin
                                        s_d.pc.pop = 1'b1; // [RQ15]
                                        s_d.pc.irq_return = s_q.instr[0];
                                        take_skip = 1'b1; // [RQ15]
                                    end
                                end
                                4'h1:
                                begin
                                    s_d.res = 8'h00;
                                    s_d.z = 1'b1;
                                end
                                4'h2, 4'h7:
                                begin
                                    sum = (nib == 4'h7) ? {1'b0, fop} + {1'b0, s_q.w}
                                                        : {1'b0, fop} + {1'b0, ~s_q.w} + 9'h001; // [RQ21]
                                    s_d.res = sum[7:0];
                                    s_d.c = sum[8]; // [RQ21]
                                    s_d.dc = (nib == 4'h7) ? ({1'b0, fop[3:0]} + {1'b0, s_q.w[3:0]} > 5'h0F)
                                                           : (fop[3:0] >= s_q.w[3:0]); // [RQ21]
                                    s_d.z = (sum[7:0] == 8'h00);
                                end
                                4'h3, 4'hA:
                                begin
                                    s_d.res = (nib == 4'h3) ? fop - 8'h01 : fop + 8'h01;
                                    s_d.z = (s_d.res == 8'h00);
                                end
                                4'h4, 4'h5, 4'h6:
                                begin
                                    s_d.res = (nib == 4'h4) ? (fop | s_q.w) : (nib == 4'h5) ? (fop & s_q.w)
                                                                                : (fop ^ s_q.w); // [RQ6]
                                    s_d.z = (s_d.res == 8'h00); // [RQ6]
                                end
                                4'h8:
                                begin
                                    s_d.z = (fop == 8'h00);
                                end
                                4'h9:
                                begin
                                    s_d.res = ~fop;
                                    s_d.z = (fop == 8'hFF);
                                end
                                4'hB, 4'hF:
                                begin
                                    s_d.res = (nib == 4'hB) ? fop - 8'h01 : fop + 8'h01; // [RQ8]
                                    take_skip = (s_d.res == 8'h00); // [RQ8]
                                end
                                4'hC:
                                begin
                                    s_d.res = {s_q.c, fop[7:1]}; // [RQ7]
                                    s_d.c = fop[0]; // [RQ7]
                                end
                                4'hD:
                                begin
                                    s_d.res = {fop[6:0], s_q.c}; // [RQ7]
                                    s_d.c = fop[7]; // [RQ7]
                                end
                                4'hE:
                                begin
                                    s_d.res = {fop[3:0], fop[7:4]};
                                end
                                default:
                                begin
                                    s_d.wr_file = 1'b0;
                                end
                            endcase
                            // Clear and move-W forms always target the file when bit 7 is set.
                            if ((nib == 4'h0 || nib == 4'h1) && dbit)
                            begin
                                s_d.wr_file = 1'b1;
                            end
                        end
                        2'b01:
                        begin
                            case (s_q.instr[11:10]) // [RQ9]
                                2'b00:
                                begin
                                    s_d.res = fop & ~bmask; // [RQ9]
                                    s_d.wr_file = 1'b1;
                                end
                                2'b01:
                                begin
                                    s_d.res = fop | bmask; // [RQ9]
                                    s_d.wr_file = 1'b1;
                                end
                                2'b10:
                                begin
                                    take_skip = ((fop & bmask) == 8'h00); // [RQ9]
                                end
                                default:
                                begin
                                    take_skip = ((fop & bmask) != 8'h00); // [RQ9]
                                end
                            endcase
                        end
                        2'b10:
                        begin
                            s_d.pc.load = 1'b1;
                            s_d.pc.target = s_q.instr[10:0]; // [RQ19]
                            s_d.pc.push = !s_q.instr[11]; // [RQ20]
                            take_skip = 1'b1; // [RQ20]
                        end
                        default:
                        begin
                            s_d.res = lit;
                            // Bits 9:8 under 00xx and 01xx, and bit 8 under 111x, are ignored. [RQ5]
                            case (nib[3:2])
                                2'b00:
                                begin
                                    s_d.wr_w = 1'b1; // [RQ17]
                                end
                                2'b01:
                                begin
                                    s_d.wr_w = 1'b1;
                                    s_d.pc.pop = 1'b1; // [RQ15]
                                    take_skip = 1'b1; // [RQ15]
                                end
                                2'b10:
                                begin
                                    s_d.wr_w = (nib[1:0] != 2'b11);
                                    s_d.res = (nib[1:0] == 2'b00) ? (lit | s_q.w) : (nib[1:0] == 2'b01) ? (lit & s_q.w)
                                                                                     : (lit ^ s_q.w); // [RQ16]
                                    s_d.z = s_d.wr_w ? (s_d.res == 8'h00) : s_q.z; // [RQ16]
                                end
                                default:
                                begin
                                    if (nib[1])
                                    begin
                                        sum = {1'b0, lit} + {1'b0, s_q.w}; // [RQ17]
                                        s_d.wr_w = 1'b1;
                                        s_d.res = sum[7:0];
                                        s_d.c = sum[8]; // [RQ17]
                                        s_d.dc = ({1'b0, lit[3:0]} + {1'b0, s_q.w[3:0]} > 5'h0F); // [RQ17]
                                        s_d.z = (sum[7:0] == 8'h00); // [RQ17]
                                    end
                                end
                            endcase
                        end
                    endcase
                end
            end
            default:
            begin
                // Store the result and take the next word.
                s_d.phase = rmwd_pkg::PH_DECODE;
                s_d.instr = instr_in;
                if (s_q.wr_w)
                begin
                    s_d.w = s_q.res; // [RQ2]
                end
                s_d.file.wr = s_q.wr_file; // [RQ1]
                s_d.file.wdata = s_q.res;
                s_d.presc_clr = s_q.wr_file && s_q.presc && (s_q.file.addr == TIMER_ADDR); // [RQ12]
                s_d.flush = 1'b0;
            end
        endcase

        // A taken skip or PC change turns the next cycle into a no-op. [RQ10]
        if (s_q.phase == rmwd_pkg::PH_MODIFY && !s_q.flush && take_skip)
        begin
            s_d.flush = 1'b1;
        end
        if (s_q.phase == rmwd_pkg::PH_WRITE && s_q.flush)
        begin
            s_d.flush = 1'b0;
        end
        if (s_q.phase == rmwd_pkg::PH_MODIFY)
        begin
            s_d.flush = s_q.flush ? 1'b0 : take_skip; // [RQ10]
            s_d.wr_file = s_q.flush ? 1'b0 : s_d.wr_file;
            s_d.wr_w = s_q.flush ? 1'b0 : s_d.wr_w;
        end
        if (s_q.phase == rmwd_pkg::PH_WRITE)
        begin
            s_d.flush = s_q.flush;
        end

        // APB slave: answered in the first access cycle.
        if (setup)
        begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0000_0000;
            case (paddr_in)
                `RMWD_CTRL_OFS:
                begin
                    s_d.prdata[`RMWD_CTRL_RUN] = s_q.run;
                    s_d.prdata[`RMWD_CTRL_PRESC] = s_q.presc;
                end
                `RMWD_STAT_OFS:
                begin
                    s_d.prdata[`RMWD_STAT_C] = s_q.c;
                    s_d.prdata[`RMWD_STAT_DC] = s_q.dc;
                    s_d.prdata[`RMWD_STAT_Z] = s_q.z;
                    s_d.prdata[`RMWD_STAT_PD] = s_q.pd_n;
                    s_d.prdata[`RMWD_STAT_TO] = s_q.to_n;
                    s_d.prdata[`RMWD_STAT_SLEEP] = s_q.sleeping;
                    s_d.prdata[`RMWD_STAT_W_LSB +: 8] = s_q.w;
                end
                `RMWD_DEC_OFS:
                begin
                    s_d.prdata[13:0] = s_q.instr;
                end
                default:
                begin
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
        if (psel_in && penable_in && s_q.pready && pwrite_in && paddr_in == `RMWD_CTRL_OFS)
        begin
            s_d.run = pwdata_in[`RMWD_CTRL_RUN];
            s_d.presc = pwdata_in[`RMWD_CTRL_PRESC];
            if (pwdata_in[`RMWD_CTRL_WAKE] && s_q.sleeping)
            begin
                s_d.sleeping = 1'b0;
            end
        end
        if (!(psel_in && penable_in && s_q.pready))
        begin
            s_d.prdata = setup ? s_d.prdata : s_q.prdata;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            s_q <= '0;
            s_q.phase <= rmwd_pkg::PH_DECODE;
            s_q.flush <= 1'b1;
            s_q.to_n <= 1'b1;
            s_q.pd_n <= 1'b1;
            s_q.run <= `RMWD_CTRL_RUN_RST;
            s_q.presc <= `RMWD_CTRL_PRESC_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign fetch_out = s_q.fetch;
    assign file_req_out = s_q.file;
    assign port_read_out = s_q.port_read;
    assign presc_clr_out = s_q.presc_clr;
    assign pc_req_out = s_q.pc;
    assign wdt_clr_out = s_q.wdt_clr;
    assign sleep_out = s_q.sleeping;
    assign w_out = s_q.w;
    assign status_out = {s_q.to_n, s_q.pd_n, s_q.z, s_q.dc, s_q.c};
    assign prdata_out = s_q.prdata;
    assign pready_out = s_q.pready;
    assign pslverr_out = s_q.pslverr;

endmodule

`default_nettype wire

/* verilog/rmwd_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * read-modify-write instruction decoder.
 * Assumes a 32-bit APB slave that decodes byte addresses in twelve bits.
 */
`ifndef RMWD_REGS_SVH
`define RMWD_REGS_SVH

// Register byte offsets.
`define RMWD_CTRL_OFS 12'h000
`define RMWD_STAT_OFS 12'h004
`define RMWD_DEC_OFS 12'h008

// Control register fields.
`define RMWD_CTRL_RUN 0
`define RMWD_CTRL_PRESC 1
`define RMWD_CTRL_WAKE 2
`define RMWD_CTRL_RUN_RST 1'b1
`define RMWD_CTRL_PRESC_RST 1'b0

// Status register fields.
`define RMWD_STAT_C 0
`define RMWD_STAT_DC 1
`define RMWD_STAT_Z 2
`define RMWD_STAT_PD 3
`define RMWD_STAT_TO 4
`define RMWD_STAT_SLEEP 5
`define RMWD_STAT_W_LSB 8

// Oscillator periods in one instruction cycle, one clock each.
`define RMWD_OSC_PER_CYCLE 4

`endif

/* verilog/rmwd_pkg.sv */
/*
 * Types shared by the read-modify-write instruction decoder.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package rmwd_pkg;

    // Quarters of one instruction cycle, Gray coded.
    typedef enum logic [1:0] {
        PH_DECODE = 2'b00,
        PH_READ = 2'b01,
        PH_MODIFY = 2'b11,
        PH_WRITE = 2'b10
    } rmwd_phase_t;

    // Request to the file register array.
    typedef struct packed {
        logic [6:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } rmwd_file_req_t;

    // Request to the program counter and stack.
    typedef struct packed {
        logic load;
        logic [10:0] target;
        logic push;
        logic pop;
        logic irq_return;
    } rmwd_pc_req_t;

    // All state of the decoder.
    typedef struct packed {
        rmwd_phase_t phase;
        logic [13:0] instr;
        logic flush;
        logic [7:0] w;
        logic c;
        logic dc;
        logic z;
        logic to_n;
        logic pd_n;
        logic sleeping;
        logic [7:0] fval;
        logic [7:0] res;
        logic wr_file;
        logic wr_w;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic run;
        logic presc;
        logic fetch;
        logic port_read;
        logic presc_clr;
        logic wdt_clr;
        rmwd_file_req_t file;
        rmwd_pc_req_t pc;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } rmwd_state_t;

endpackage

`default_nettype wire

/* tb/rmwd_decoder_sva.sv */
/* Concurrent checks on the decoder's ports.
   Assumes it is bound into every decoder instance by the statement below. */
`default_nettype none
module rmwd_decoder_sva #(
    parameter logic [6:0] PORT_ADDR = 7'h05,
    parameter logic [6:0] TIMER_ADDR = 7'h01
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Core side.
    input wire logic fetch_out,
    input wire rmwd_pkg::rmwd_file_req_t file_req_out,
    input wire logic port_read_out,
    input wire logic presc_clr_out,
    input wire logic wdt_clr_out,
    input wire logic sleep_out,
    input wire logic [4:0] status_out,
    // APB side.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_quiet_quarters;
        !fetch_out [*3];
    endsequence
    sequence s_no_reread;
        !file_req_out.rd [*3];
    endsequence
    a_fetch_spacing: assert property (fetch_out |=> s_quiet_quarters) else $error("fetch spacing wrong");
    a_read_single: assert property (file_req_out.rd |=> s_no_reread) else $error("file read repeated");
    a_read_before_write: assert property (file_req_out.wr |-> $past(file_req_out.rd, 3))
        else $error("write without read");
    a_port_read: assert property (port_read_out |-> $past(file_req_out.rd) && file_req_out.addr == PORT_ADDR)
        else $error("port read pulse wrong");
    a_presc_clear: assert property (presc_clr_out |-> file_req_out.wr && file_req_out.addr == TIMER_ADDR)
        else $error("prescaler clear wrong");
    a_wdt_status: assert property (wdt_clr_out |-> ##[0:4] status_out[4:3] == 2'b11)
        else $error("watchdog status not set");
    a_sleep_pd: assert property (sleep_out |-> ##[0:4] !status_out[3]) else $error("powerdown bit not cleared");
    a_apb_ready: assert property (psel_in && !penable_in |=> pready_out) else $error("no ready in access");
endmodule
bind rmwd_decoder rmwd_decoder_sva #(.PORT_ADDR(PORT_ADDR), .TIMER_ADDR(TIMER_ADDR)) rmwd_decoder_sva_i (
    .clk_in, .sys_rst_in, .fetch_out, .file_req_out, .port_read_out, .presc_clr_out, .wdt_clr_out,
    .sleep_out, .status_out, .psel_in, .penable_in, .pready_out);
`default_nettype wire

/* tb/rmwd_prog_mem.sv */
/* Program memory and file register array facing the decoder.
   Assumes the bench loads rom and file_q before reset is released. */
`default_nettype none
module rmwd_prog_mem (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Instruction fetch.
    input wire logic fetch_in,
    output logic [13:0] instr_out,
    // File registers.
    input wire rmwd_pkg::rmwd_file_req_t file_req_in,
    output logic [7:0] file_rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [13:0] rom [0:15];
    logic [7:0] file_q [0:127];
    logic [3:0] idx_q;
    assign instr_out = rom[idx_q];
    // Read data stands only while the read strobe does; otherwise the bus shows its inverse.
    assign file_rdata_out = file_req_in.rd ? file_q[file_req_in.addr] : ~file_q[file_req_in.addr];
    always @(posedge clk_in)
    begin
        if (sys_rst_in)
            idx_q <= 4'h0;
        else if (fetch_in)
            idx_q <= idx_q + 4'h1;
        if (file_req_in.wr)
            file_q[file_req_in.addr] <= file_req_in.wdata;
    end
endmodule
`default_nettype wire

/* tb/rmwd_decoder_tb_top.sv */
/* Self-checking bench of the decoder: a short program plus register accesses.
   Assumes the checker binds itself and the partner serves words and file data. */
`include "rmwd_regs.svh"
`default_nettype none
module rmwd_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic [13:0] instr_in;
    logic [7:0] file_rdata_in;
    logic fetch_out, port_read_out, presc_clr_out, wdt_clr_out, sleep_out, pready_out, pslverr_out;
    logic [7:0] w_out;
    logic [4:0] status_out;
    logic [31:0] prdata_out;
    rmwd_pkg::rmwd_file_req_t file_req_out;
    rmwd_pkg::rmwd_pc_req_t pc_req_out;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_port = 0;
    int n_presc = 0;
    int n_wdt = 0;
    int n_call = 0;
    rmwd_decoder rmwd_decoder_i (.clk_in, .sys_rst_in, .instr_in, .fetch_out, .file_rdata_in, .port_pins_in(8'h5A),
        .file_req_out, .port_read_out, .presc_clr_out, .pc_req_out, .wdt_clr_out, .sleep_out, .w_out,
        .status_out, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out);
    rmwd_prog_mem rmwd_prog_mem_i (.clk_in, .sys_rst_in, .fetch_in(fetch_out), .instr_out(instr_in),
        .file_req_in(file_req_out), .file_rdata_out(file_rdata_in));
    initial forever #20 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        n_port += port_read_out;
        n_presc += presc_clr_out;
        n_wdt += wdt_clr_out;
        n_call += pc_req_out.load && pc_req_out.push && pc_req_out.target == 11'h005;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    task automatic complete_run;
        $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
        output logic err);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready_out !== 1'b1 && n < 20);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        check(pready_out, 1'b1);
        if (pready_out !== 1'b1)
            complete_run();
    endtask
    // Reset value, prescaler hand-over to the timer, and an unmapped word.
    task automatic t_regs;
        logic [31:0] rd;
        logic err;
        apb(1'b0, `RMWD_CTRL_OFS, 32'h0, rd, err);
        check(rd, 32'h0000_0001);
        apb(1'b1, `RMWD_CTRL_OFS, 32'h0000_0003, rd, err);
        apb(1'b0, 12'h00C, 32'h0, rd, err);
        check(err, 1'b1);
    endtask
    task automatic t_program;
        int n;
        for (n = 0; n < 300 && sleep_out !== 1'b1; n++)
            @(posedge clk_in);
        check(sleep_out, 1'b1);
        if (sleep_out !== 1'b1)
            complete_run();
        else
        begin
            check(w_out, 8'h00);
            check(status_out, 5'b10111);
            check(rmwd_prog_mem_i.file_q[7'h20], 8'h02);
            check(rmwd_prog_mem_i.file_q[7'h01], 8'h81);
            check(rmwd_prog_mem_i.file_q[7'h05], 8'h5A);
            check(n_port, 1);
            check(n_presc, 1);
            check(n_wdt, 1);
        end
    endtask
    task automatic t_wake;
        logic [31:0] rd;
        logic err;
        apb(1'b0, `RMWD_STAT_OFS, 32'h0, rd, err);
        check(rd, 32'h0000_0037);
        apb(1'b1, `RMWD_CTRL_OFS, 32'h0000_0007, rd, err);
        @(posedge clk_in);
        check(sleep_out, 1'b0);
        repeat (8) @(posedge clk_in);
        check(n_call, 1);
    endtask
    initial
    begin
        rmwd_prog_mem_i.rom = '{14'h0000, 14'h303C, 14'h3A3C, 14'h3881, 14'h00A0, 14'h0081, 14'h0DA0, 14'h0620,
            14'h0885, 14'h3E7D, 14'h1CA0, 14'h30FF, 14'h0064, 14'h0063, 14'h2005, 14'h0000};
        rmwd_prog_mem_i.file_q[7'h05] = 8'hFF;
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_regs();
        t_program();
        t_wake();
        complete_run();
    end
endmodule
`default_nettype wire
